// file: core/ctrl_flags_pkg.sv
// Purpose: constants for the processor control flag logic
// Assumes: control registers reached by index through move-to/from ports
// Notes: bit positions and masks used by the top module, other constants split among the fp gate, privilege check and top module
package ctrl_flags_pkg;
    localparam logic [3:0]  IDX_MACHINE  = 4'h0;
    localparam logic [3:0]  IDX_PAGEBASE = 4'h3;
    localparam logic [3:0]  IDX_EXT      = 4'h4;
    // machine control bit positions
    localparam int B_MONITOR = 1;
    localparam int B_TRAPSW  = 2;
    localparam int B_TASKSW  = 3;
    localparam int B_NUMERR  = 5;
    localparam int B_WGUARD  = 16;
    localparam int B_AMASK   = 18;
    localparam int B_NOWT    = 29;
    localparam int B_CACHEOFF = 30;
    localparam int B_PAGING  = 31;
    // page base bit positions
    localparam int B_PWT = 3;
    localparam int B_PCD = 4;
    // extension bit positions
    localparam int B_V86  = 0;
    localparam int B_PVI  = 1;
    localparam int B_TSD  = 2;
    localparam int B_DE   = 3;
    localparam int B_PSE  = 4;
    localparam int B_PAE  = 5;
    localparam int B_MCE  = 6;
    localparam int B_PGE  = 7;
    localparam int B_PCE  = 8;
    localparam int B_FXSR = 9;
    localparam int B_XMMX = 10;
    localparam logic [31:0] MACHINE_MASK  = 32'he005003f;
    localparam logic [31:0] PAGEBASE_MASK = 32'hfffff018;
    localparam logic [31:0] EXT_MASK      = 32'h000007ff;
    localparam logic [31:0] EXT_RESET     = 32'h00000000;
    localparam logic [15:0] CW_PRESENT    = 16'h037f;
    localparam logic [15:0] CW_ABSENT     = 16'hffff;
    localparam logic [7:0]  VEC_NO_DEVICE = 8'h07;
    localparam logic [1:0]  CPL_KERNEL    = 2'h0;
    localparam logic [1:0]  CPL_USER      = 2'h3;
    localparam logic [2:0]  DBG_ALIAS_LOW  = 3'h4;
    localparam logic [2:0]  DBG_ALIAS_HIGH = 3'h5;
endpackage

// file: core/fpu_gate.sv
// Purpose: floating-point dispatch, trap and init sequencing
// Assumes: one fp request at a time, unit reports completion
// Notes: fp_ready is combinational
`timescale 1ns/1ps
`default_nettype none
module fpu_gate #(
    parameter bit FPU_PRESENT = 1'b1
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    // flags
    input  wire logic        trap_to_software_flag,
    input  wire logic        coproc_monitor_flag,
    input  wire logic        task_switched_flag,
    // instruction side
    input  wire logic        fp_req,
    input  wire logic        fp_is_wait,
    input  wire logic        fp_is_init,
    output logic             fp_ready,
    // unit side
    output logic             fp_issue,
    input  wire logic        fpu_done,
    input  wire logic        fpu_err_in,
    // results
    output logic             nm_trap,
    output logic [7:0]       nm_vector,
    output logic             fpu_err,
    output logic [15:0]      fpu_ctrl_word
);
    import ctrl_flags_pkg::*;
    typedef struct packed {
        logic        busy;
        logic        issue;
        logic        trap;
        logic        err;
        logic [15:0] cw;
    } fg_s;
    fg_s s_q, s_d;
    logic take;

    assign fp_ready = !s_q.busy || fpu_done;
    assign take     = fp_req && fp_ready;

    always_comb begin
        s_d       = s_q;
        s_d.issue = 1'b0;
        s_d.trap  = 1'b0;
        if (fpu_done) begin
            s_d.busy = 1'b0;
        end
        if (take) begin
            if (fp_is_wait) begin
                s_d.trap = coproc_monitor_flag && task_switched_flag;
            end else if (trap_to_software_flag) begin
                s_d.trap = 1'b1;
            end else begin
                s_d.issue = 1'b1;
                s_d.busy  = 1'b1;
                if (fp_is_init) begin
                    s_d.cw  = FPU_PRESENT ? CW_PRESENT : CW_ABSENT;
                    s_d.err = 1'b0;
                end
            end
        end
        // set wins over init clear
        if (fpu_err_in) begin
            s_d.err = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '{busy: 1'b0, issue: 1'b0, trap: 1'b0, err: 1'b0, cw: CW_PRESENT};
        end else begin
            s_q <= s_d;
        end
    end

    assign fp_issue      = s_q.issue;
    assign nm_trap       = s_q.trap;
    assign nm_vector     = VEC_NO_DEVICE;
    assign fpu_err       = s_q.err;
    assign fpu_ctrl_word = s_q.cw;
endmodule
`default_nettype wire

// file: core/priv_check.sv
// Purpose: privilege and alignment checks steered by control flags
// Assumes: request pulses one cycle
// Notes: fault outputs registered, one cycle after request
`timescale 1ns/1ps
`default_nettype none
module priv_check (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    // flags
    input  wire logic        perf_counter_user_read,
    input  wire logic        timestamp_privilege_lock,
    input  wire logic        dbg_reg_alias_trap,
    input  wire logic        align_check_mask,
    input  wire logic        align_check_flag,
    // requests
    input  wire logic [1:0]  cpl,
    input  wire logic        pmc_req,
    input  wire logic        tsc_req,
    input  wire logic        dbg_req,
    input  wire logic [2:0]  dbg_num,
    input  wire logic        mem_req,
    input  wire logic        mem_misaligned,
    // faults
    output logic             gp_fault,
    output logic             ud_fault,
    output logic             ac_fault
);
    import ctrl_flags_pkg::*;
    typedef struct packed {
        logic gp;
        logic ud;
        logic ac;
    } pc_s;
    pc_s s_q, s_d;

    always_comb begin
        s_d = '0;
        if (pmc_req && !perf_counter_user_read && cpl != CPL_KERNEL) begin
            s_d.gp = 1'b1;
        end
        if (tsc_req && timestamp_privilege_lock && cpl != CPL_KERNEL) begin
            s_d.gp = 1'b1;
        end
        if (dbg_req && dbg_reg_alias_trap &&
            (dbg_num == DBG_ALIAS_LOW || dbg_num == DBG_ALIAS_HIGH)) begin
            s_d.ud = 1'b1;
        end
        s_d.ac = mem_req && mem_misaligned && align_check_mask &&
                 align_check_flag && cpl == CPL_USER;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign gp_fault = s_q.gp;
    assign ud_fault = s_q.ud;
    assign ac_fault = s_q.ac;
endmodule
`default_nettype wire

// file: core/processor_control_flag_logic.sv
// Purpose: control register flags and their effects
// Assumes: registers moved by index over cr_* ports, one access a cycle
// Notes: read data registered, one cycle after cr_rd
`timescale 1ns/1ps
`default_nettype none
module processor_control_flag_logic #(
    parameter bit          FPU_PRESENT   = 1'b1,
    parameter logic [31:0] MACHINE_RESET = 32'h00000000,
    parameter logic [31:0] PAGEBASE_RESET = 32'h00000000
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    // control register moves
    input  wire logic        cr_wr,
    input  wire logic        cr_rd,
    input  wire logic [3:0]  cr_idx,
    input  wire logic [31:0] cr_wdata,
    output logic [31:0]      cr_rdata,
    output logic             cr_bad_idx,
    // task switch flag events
    input  wire logic        task_switch_evt,
    input  wire logic        task_switch_clr,
    // fp instruction path
    input  wire logic        fp_req,
    input  wire logic        fp_is_wait,
    input  wire logic        fp_is_init,
    output logic             fp_ready,
    output logic             fp_issue,
    input  wire logic        fpu_done,
    input  wire logic        fpu_err_in,
    output logic             nm_trap,
    output logic [7:0]       nm_vector,
    output logic             fpu_err,
    output logic [15:0]      fpu_ctrl_word,
    // split operand store
    input  wire logic        split_store,
    input  wire logic        split_lo_ok,
    input  wire logic        split_hi_fault,
    output logic             split_lo_we,
    output logic             split_hi_we,
    // privilege checks
    input  wire logic [1:0]  cpl,
    input  wire logic        pmc_req,
    input  wire logic        tsc_req,
    input  wire logic        dbg_req,
    input  wire logic [2:0]  dbg_num,
    input  wire logic        mem_req,
    input  wire logic        mem_misaligned,
    input  wire logic        align_check_flag,
    output logic             gp_fault,
    output logic             ud_fault,
    output logic             ac_fault,
    // supervisor writes and hardware errors
    input  wire logic        sup_write,
    input  wire logic        page_read_only,
    output logic             wguard_fault,
    input  wire logic        hw_error,
    output logic             mc_exception,
    // translation control
    output logic             tlb_flush,
    output logic             tlb_keep_global,
    // flag outputs
    output logic             wide_physical_address_ext,
    output logic             large_page_ext,
    output logic             v86_interrupt_ext,
    output logic             protected_virtual_irq_ext,
    output logic             numeric_error_select,
    output logic             os_state_save_support,
    output logic             os_simd_fault_support,
    output logic             paging_on,
    // cache control
    output logic             cache_enable,
    input  wire logic        cache_hit,
    output logic             wt_inval_allow,
    // external cache hint pins
    input  wire logic        bus_cycle,
    input  wire logic        bus_unpaged,
    input  wire logic        pte_cache_off,
    input  wire logic        pte_write_through,
    output logic             ext_cache_inhibit_pin,
    output logic             ext_write_through_pin
);
    import ctrl_flags_pkg::*;

    typedef struct packed {
        logic [31:0] mc;
        logic [31:0] pb;
        logic [31:0] ext;
        logic [31:0] rdata;
        logic        bad;
        logic        flush;
        logic        keep_g;
        logic        lo_we;
        logic        hi_we;
        logic        wg;
        logic        mc_x;
        logic        pin_cd;
        logic        pin_wt;
    } st_s;
    st_s s_q, s_d;

    logic idx_ok;
    logic [31:0] rd_mux;

    assign idx_ok = cr_idx == IDX_MACHINE || cr_idx == IDX_PAGEBASE || cr_idx == IDX_EXT;

    always_comb begin
        case (cr_idx)
            IDX_MACHINE:  rd_mux = s_q.mc & MACHINE_MASK;
            IDX_PAGEBASE: rd_mux = s_q.pb & PAGEBASE_MASK;
            IDX_EXT:      rd_mux = s_q.ext & EXT_MASK;
            default:      rd_mux = '0;
        endcase
    end

    always_comb begin
        s_d       = s_q;
        s_d.flush = 1'b0;
        s_d.bad   = 1'b0;
        if (cr_wr) begin
            case (cr_idx)
                IDX_MACHINE:  s_d.mc = cr_wdata & MACHINE_MASK;
                IDX_PAGEBASE: begin
                    s_d.pb     = cr_wdata & PAGEBASE_MASK;
                    s_d.flush  = 1'b1;
                    s_d.keep_g = s_q.ext[B_PGE];
                end
                IDX_EXT:      s_d.ext = cr_wdata & EXT_MASK;
                default:      s_d.bad = 1'b1;
            endcase
        end
        if (cr_rd) begin
            s_d.rdata = rd_mux;
            s_d.bad   = !idx_ok;
        end
        // set after clear, so a switch in the clear cycle wins
        if (task_switch_clr) begin
            s_d.mc[B_TASKSW] = 1'b0;
        end
        if (task_switch_evt) begin
            s_d.mc[B_TASKSW] = 1'b1;
        end
        // lower half stays on upper fault
        s_d.lo_we = split_store && split_lo_ok;
        s_d.hi_we = split_store && split_lo_ok && !split_hi_fault;
        s_d.wg    = sup_write && page_read_only && s_q.mc[B_WGUARD];
        s_d.mc_x  = hw_error && s_q.ext[B_MCE];
        if (bus_cycle) begin
            if (s_q.mc[B_PAGING] && bus_unpaged) begin
                s_d.pin_cd = s_q.pb[B_PCD];
                s_d.pin_wt = s_q.pb[B_PWT];
            end else begin
                s_d.pin_cd = pte_cache_off;
                s_d.pin_wt = pte_write_through;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s_q        <= '0;
            s_q.mc     <= MACHINE_RESET & MACHINE_MASK;
            s_q.pb     <= PAGEBASE_RESET & PAGEBASE_MASK;
            s_q.ext    <= EXT_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    fpu_gate #(
        .FPU_PRESENT (FPU_PRESENT)
    ) u_fpu_gate (
        .clk_sys               (clk_sys),
        .arst_n                (arst_n),
        .trap_to_software_flag (s_q.mc[B_TRAPSW]),
        .coproc_monitor_flag   (s_q.mc[B_MONITOR]),
        .task_switched_flag    (s_q.mc[B_TASKSW]),
        .fp_req                (fp_req),
        .fp_is_wait            (fp_is_wait),
        .fp_is_init            (fp_is_init),
        .fp_ready              (fp_ready),
        .fp_issue              (fp_issue),
        .fpu_done              (fpu_done),
        .fpu_err_in            (fpu_err_in),
        .nm_trap               (nm_trap),
        .nm_vector             (nm_vector),
        .fpu_err               (fpu_err),
        .fpu_ctrl_word         (fpu_ctrl_word)
    );

    priv_check u_priv_check (
        .clk_sys                  (clk_sys),
        .arst_n                   (arst_n),
        .perf_counter_user_read   (s_q.ext[B_PCE]),
        .timestamp_privilege_lock (s_q.ext[B_TSD]),
        .dbg_reg_alias_trap       (s_q.ext[B_DE]),
        .align_check_mask         (s_q.mc[B_AMASK]),
        .align_check_flag         (align_check_flag),
        .cpl                      (cpl),
        .pmc_req                  (pmc_req),
        .tsc_req                  (tsc_req),
        .dbg_req                  (dbg_req),
        .dbg_num                  (dbg_num),
        .mem_req                  (mem_req),
        .mem_misaligned           (mem_misaligned),
        .gp_fault                 (gp_fault),
        .ud_fault                 (ud_fault),
        .ac_fault                 (ac_fault)
    );

    assign cr_rdata   = s_q.rdata;
    assign cr_bad_idx = s_q.bad;
    assign tlb_flush       = s_q.flush;
    assign tlb_keep_global = s_q.keep_g;
    assign split_lo_we  = s_q.lo_we;
    assign split_hi_we  = s_q.hi_we;
    assign wguard_fault = s_q.wg;
    assign mc_exception = s_q.mc_x;
    assign wide_physical_address_ext = s_q.ext[B_PAE];
    assign large_page_ext            = s_q.ext[B_PSE];
    assign v86_interrupt_ext         = s_q.ext[B_V86];
    assign protected_virtual_irq_ext = s_q.ext[B_PVI];
    assign numeric_error_select      = s_q.mc[B_NUMERR];
    assign os_state_save_support     = s_q.ext[B_FXSR];
    assign os_simd_fault_support     = s_q.ext[B_XMMX];
    assign paging_on                 = s_q.mc[B_PAGING];
    assign cache_enable   = !s_q.mc[B_CACHEOFF];
    assign wt_inval_allow = !(s_q.mc[B_NOWT] && cache_hit);
    assign ext_cache_inhibit_pin = s_q.pin_cd;
    assign ext_write_through_pin = s_q.pin_wt;
endmodule
`default_nettype wire

// file: verif/ctrl_flags_props.sv
// Purpose: port-level checks for control flag logic
// Assumes: unit present, default reset parameters
// Notes: faults, flush and pins are registered
`timescale 1ns/1ps
`default_nettype none
module ctrl_flags_props
    import ctrl_flags_pkg::*;
(
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        arst_n,
    // register moves
    input wire logic        cr_wr,
    input wire logic [3:0]  cr_idx,
    input wire logic        tlb_flush,
    // fp path
    input wire logic        fp_req,
    input wire logic        fp_is_init,
    input wire logic        fp_ready,
    input wire logic        fp_issue,
    input wire logic        fpu_done,
    input wire logic        fpu_err_in,
    input wire logic        nm_trap,
    input wire logic [7:0]  nm_vector,
    input wire logic        fpu_err,
    input wire logic [15:0] fpu_ctrl_word,
    // privilege checks
    input wire logic [1:0]  cpl,
    input wire logic        pmc_req,
    input wire logic        tsc_req,
    input wire logic        dbg_req,
    input wire logic [2:0]  dbg_num,
    input wire logic        mem_req,
    input wire logic        mem_misaligned,
    input wire logic        align_check_flag,
    input wire logic        gp_fault,
    input wire logic        ud_fault,
    input wire logic        ac_fault,
    // cache and pins
    input wire logic        cache_hit,
    input wire logic        wt_inval_allow,
    input wire logic        bus_cycle,
    input wire logic        ext_cache_inhibit_pin,
    input wire logic        ext_write_through_pin
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    chk_busy_blocks: assert property (fp_issue && !fpu_done |-> !fp_ready)
        else $error("fp ready while busy");
    chk_trap_vector: assert property (nm_trap |-> nm_vector == VEC_NO_DEVICE && !fp_issue)
        else $error("trap vector or issue wrong");
    chk_init_clean: assert property ($past(fp_req && fp_ready && fp_is_init && !fpu_err_in) && !nm_trap |->
        !fpu_err && fpu_ctrl_word == CW_PRESENT)
        else $error("init left error or bad word");
    chk_gp_cause: assert property (gp_fault |-> $past((pmc_req || tsc_req) && cpl != 2'h0))
        else $error("gp fault without cause");
    chk_ud_cause: assert property (ud_fault |-> $past(dbg_req) && $past(dbg_num) inside {3'h4, 3'h5})
        else $error("ud fault without cause");
    chk_ac_cause: assert property (ac_fault |->
        $past(mem_req && mem_misaligned && align_check_flag && cpl == 2'h3))
        else $error("ac fault without cause");
    chk_flush_pulse: assert property (cr_wr && cr_idx == IDX_PAGEBASE |=> tlb_flush ##1 !tlb_flush)
        else $error("flush pulse wrong");
    chk_miss_allows: assert property (!cache_hit |-> wt_inval_allow)
        else $error("write-through blocked on miss");
    chk_pins_hold: assert property (!bus_cycle |=>
        $stable({ext_cache_inhibit_pin, ext_write_through_pin}))
        else $error("hint pins moved without bus cycle");

    cov_trap: cover property (nm_trap);
    cov_issue: cover property (fp_issue);
    cov_alias: cover property (ud_fault);
endmodule
`default_nettype wire

// file: verif/fpu_unit_model.sv
// Purpose: floating-point unit stand-in answering issued work
// Assumes: one issue outstanding at a time
// Notes: latency and error reply chosen by the bench
`timescale 1ns/1ps
`default_nettype none
module fpu_unit_model (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       arst_n,
    // bench control
    input  wire logic [3:0] lat,
    input  wire logic       err_on,
    // unit handshake
    input  wire logic       fp_issue,
    output logic            fpu_done,
    output logic            fpu_err_in
);
    logic [3:0] cnt_q;
    // lat 1 answers two cycles after fp_issue, each larger value adds a cycle, lat 0 never answers
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q      <= 4'h0;
            fpu_done   <= 1'b0;
            fpu_err_in <= 1'b0;
        end else begin
            fpu_done   <= 1'b0;
            fpu_err_in <= 1'b0;
            if (fp_issue) begin
                cnt_q <= lat;
            end else if (cnt_q != 4'h0) begin
                cnt_q      <= cnt_q - 4'h1;
                fpu_done   <= (cnt_q == 4'h1);
                fpu_err_in <= err_on && (cnt_q == 4'h1);
            end
        end
    end
endmodule
`default_nettype wire

// file: verif/processor_control_flag_logic_bench.sv
// Purpose: self-checking bench for control flag logic
// Assumes: unit stand-in answers every issue
// Notes: outputs compared 1 ns after each edge
`timescale 1ns/1ps
`default_nettype none
module processor_control_flag_logic_bench;
    logic [31:0] cr_wdata = 32'h0, cr_rdata;
    logic [15:0] fpu_ctrl_word;
    logic [7:0]  nm_vector;
    logic [3:0]  cr_idx = 4'h0, lat = 4'h4;
    logic [2:0]  dbg_num = 3'h4;
    logic [1:0]  cpl = 2'h0;
    logic clk_sys = 1'b0, arst_n = 1'b0, cr_wr = 1'b0, cr_rd = 1'b0, task_switch_evt = 1'b0, err_on = 1'b0;
    logic fp_req = 1'b0, fp_is_wait = 1'b0, fp_is_init = 1'b0, split_store = 1'b0, split_lo_ok = 1'b0;
    logic split_hi_fault = 1'b0, pmc_req = 1'b0, tsc_req = 1'b0, dbg_req = 1'b0, mem_req = 1'b0;
    logic mem_misaligned = 1'b0, align_check_flag = 1'b0, cache_hit = 1'b0, bus_cycle = 1'b0, page_read_only = 1'b0;
    logic bus_unpaged = 1'b0, pte_cache_off = 1'b0, pte_write_through = 1'b0, sup_write = 1'b0, hw_error = 1'b0;
    logic cr_bad_idx, fp_ready, fp_issue, fpu_done, fpu_err_in, nm_trap, fpu_err, split_lo_we, split_hi_we;
    logic gp_fault, ud_fault, ac_fault, tlb_flush, tlb_keep_global, wide_physical_address_ext;
    logic large_page_ext, v86_interrupt_ext, protected_virtual_irq_ext, numeric_error_select;
    logic os_state_save_support, os_simd_fault_support, paging_on, cache_enable, wt_inval_allow;
    logic ext_cache_inhibit_pin, ext_write_through_pin, wguard_fault, mc_exception, task_switch_clr = 1'b0;
    int   fail_count = 0, checks_done = 0;

    processor_control_flag_logic u_processor_control_flag_logic (
        .clk_sys, .arst_n, .cr_wr, .cr_rd, .cr_idx, .cr_wdata, .cr_rdata, .cr_bad_idx, .task_switch_evt,
        .task_switch_clr, .fp_req, .fp_is_wait, .fp_is_init, .fp_ready, .fp_issue, .fpu_done,
        .fpu_err_in, .nm_trap, .nm_vector, .fpu_err, .fpu_ctrl_word, .split_store, .split_lo_ok,
        .split_hi_fault, .split_lo_we, .split_hi_we, .cpl, .pmc_req, .tsc_req, .dbg_req, .dbg_num, .mem_req,
        .mem_misaligned, .align_check_flag, .gp_fault, .ud_fault, .ac_fault, .sup_write,
        .page_read_only, .wguard_fault, .hw_error, .mc_exception, .tlb_flush,
        .tlb_keep_global, .wide_physical_address_ext, .large_page_ext, .v86_interrupt_ext,
        .protected_virtual_irq_ext, .numeric_error_select, .os_state_save_support, .os_simd_fault_support,
        .paging_on, .cache_enable, .cache_hit, .wt_inval_allow, .bus_cycle, .bus_unpaged, .pte_cache_off,
        .pte_write_through, .ext_cache_inhibit_pin, .ext_write_through_pin
    );
    fpu_unit_model u_fpu_unit_model (.clk_sys, .arst_n, .lat, .err_on, .fp_issue, .fpu_done, .fpu_err_in);

    initial forever #5 clk_sys = ~clk_sys;

    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    task wr(input logic [3:0] i, input logic [31:0] d);
        @(posedge clk_sys);
        cr_wr <= 1'b1;
        cr_idx <= i;
        cr_wdata <= d;
        @(posedge clk_sys);
        cr_wr <= 1'b0;
    endtask
    task rd(input logic [3:0] i, input logic [31:0] e);
        @(posedge clk_sys);
        cr_rd <= 1'b1;
        cr_idx <= i;
        @(posedge clk_sys);
        cr_rd <= 1'b0;
        #1 cmp("rdata", e, cr_rdata);
    endtask
    task fp(input logic w, input logic i, input logic [1:0] e);
        #1;
        for (int n = 0; n < 50 && fp_ready !== 1'b1; n++) begin
            @(posedge clk_sys);
            #1;
        end
        @(posedge clk_sys);
        fp_req <= 1'b1;
        fp_is_wait <= w;
        fp_is_init <= i;
        @(posedge clk_sys);
        fp_req <= 1'b0;
        #1 cmp("trap_issue", 32'(e), 32'({nm_trap, fp_issue}));
    endtask
    task flt(input logic [5:0] r, input logic [1:0] c, input logic [2:0] num, input logic [2:0] e);
        @(posedge clk_sys);
        {mem_misaligned, align_check_flag, mem_req, dbg_req, tsc_req, pmc_req} <= r;
        cpl <= c;
        dbg_num <= num;
        @(posedge clk_sys);
        {mem_misaligned, align_check_flag, mem_req, dbg_req, tsc_req, pmc_req} <= 6'h0;
        #1 cmp("faults", 32'(e), 32'({gp_fault, ud_fault, ac_fault}));
    endtask
    task bus(input logic u, input logic [1:0] p, input logic [1:0] e);
        @(posedge clk_sys);
        bus_cycle <= 1'b1;
        bus_unpaged <= u;
        {pte_cache_off, pte_write_through} <= p;
        @(posedge clk_sys);
        bus_cycle <= 1'b0;
        #1 cmp("pins", 32'(e), 32'({ext_cache_inhibit_pin, ext_write_through_pin}));
    endtask

    task t_reset;
        rd(4'h4, 32'h0);
        rd(4'h7, 32'h0);
        cmp("bad_idx", 32'h1, 32'(cr_bad_idx));
        cmp("ctrl_word", 32'h037f, 32'(fpu_ctrl_word));
        cmp("fpu_err", 32'h0, 32'(fpu_err));
        $display("test reset done");
    endtask
    task t_regs;
        wr(4'h4, 32'hffffffff);
        rd(4'h4, 32'h000007ff);
        cmp("wide_large", 32'h3, 32'({wide_physical_address_ext, large_page_ext}));
        cmp("virt_os", 32'hf, 32'({v86_interrupt_ext, protected_virtual_irq_ext, os_state_save_support,
            os_simd_fault_support}));
        wr(4'h0, 32'hffffffff);
        rd(4'h0, 32'he005003f);
        cmp("ne_pg_cache", 32'h6, 32'({numeric_error_select, paging_on, cache_enable}));
        @(posedge clk_sys);
        cache_hit <= 1'b1;
        #1 cmp("wt_hit", 32'h0, 32'(wt_inval_allow));
        @(posedge clk_sys);
        cache_hit <= 1'b0;
        wr(4'h4, 32'h0);
        $display("test regs done");
    endtask
    task t_fp;
        wr(4'h0, 32'h0);
        fp(1'b0, 1'b0, 2'b01);
        cmp("ready", 32'h0, 32'(fp_ready));
        wr(4'h0, 32'h24);
        @(posedge clk_sys);
        {task_switch_evt, task_switch_clr} <= 2'b11;
        @(posedge clk_sys);
        {task_switch_evt, task_switch_clr} <= 2'b00;
        rd(4'h0, 32'h2c);
        fp(1'b0, 1'b0, 2'b10);
        cmp("vector", 32'h7, 32'(nm_vector));
        fp(1'b1, 1'b0, 2'b00);
        wr(4'h0, 32'h2e);
        fp(1'b1, 1'b0, 2'b10);
        wr(4'h0, 32'h0);
        err_on <= 1'b1;
        lat <= 4'h1;
        fp(1'b0, 1'b0, 2'b01);
        repeat (6) @(posedge clk_sys);
        err_on <= 1'b0;
        #1 cmp("err_set", 32'h1, 32'(fpu_err));
        fp(1'b0, 1'b1, 2'b01);
        cmp("init", 32'h037f, 32'({fpu_err, fpu_ctrl_word}));
        $display("test fp done");
    endtask
    task t_priv;
        flt(6'h01, 2'h3, 3'h4, 3'h4);
        flt(6'h04, 2'h0, 3'h4, 3'h0);
        wr(4'h4, 32'h10c);
        flt(6'h01, 2'h3, 3'h4, 3'h0);
        flt(6'h02, 2'h3, 3'h4, 3'h4);
        flt(6'h02, 2'h0, 3'h4, 3'h0);
        for (int n = 4; n < 7; n++) begin
            flt(6'h04, 2'h0, 3'(n), (n == 6) ? 3'h0 : 3'h2);
        end
        wr(4'h0, 32'h40000);
        flt(6'h38, 2'h3, 3'h4, 3'h1);
        flt(6'h38, 2'h0, 3'h4, 3'h0);
        flt(6'h28, 2'h3, 3'h4, 3'h0);
        $display("test priv done");
    endtask
    task t_pins;
        wr(4'h4, 32'hc0);
        wr(4'h3, 32'h10);
        #1 cmp("flush", 32'h3, 32'({tlb_flush, tlb_keep_global}));
        wr(4'h0, 32'h80000000);
        bus(1'b1, 2'b01, 2'b10);
        bus(1'b0, 2'b01, 2'b01);
        wr(4'h0, 32'h10000);
        bus(1'b1, 2'b01, 2'b01);
        $display("test pins done");
    endtask
    task t_split;
        @(posedge clk_sys);
        {split_store, split_lo_ok, split_hi_fault, sup_write, page_read_only, hw_error} <= 6'h3f;
        @(posedge clk_sys);
        {split_hi_fault, sup_write} <= 2'h0;
        #1 cmp("split", 32'hb, 32'({split_lo_we, split_hi_we, wguard_fault, mc_exception}));
        @(posedge clk_sys);
        split_store <= 1'b0;
        #1 cmp("split", 32'hd, 32'({split_lo_we, split_hi_we, wguard_fault, mc_exception}));
        $display("test split done");
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge clk_sys);
        arst_n <= 1'b1;
        t_reset;
        t_regs;
        t_fp;
        t_priv;
        t_pins;
        t_split;
        conclude;
    end
    // whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_sys);
        fail_count++;
        conclude;
    end
endmodule

bind processor_control_flag_logic ctrl_flags_props u_ctrl_flags_props (
    .clk_sys, .arst_n, .cr_wr, .cr_idx, .tlb_flush, .fp_req, .fp_is_init, .fp_ready, .fp_issue, .fpu_done,
    .nm_trap, .nm_vector, .fpu_err, .fpu_ctrl_word, .cpl, .pmc_req, .tsc_req, .dbg_req, .dbg_num, .mem_req,
    .mem_misaligned, .align_check_flag, .gp_fault, .ud_fault, .ac_fault, .cache_hit, .wt_inval_allow,
    .fpu_err_in, .bus_cycle, .ext_cache_inhibit_pin, .ext_write_through_pin
);
`default_nettype wire
